// ==== rtl/sar_readout.sv ====
// sar converter sequencing and serial result read-out
`timescale 1ns/1ps
`default_nettype none
module sar_readout
	import sar_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// serial link with host
	input wire logic serClk,
	input wire logic convSelB,
	output logic serDataOut,
	output logic serDataOeB,
	// comparator model of the analog sample: code of the held input
	input wire logic [SAR_BITS-1:0] analogCode,
	// result stream
	output logic resultValid,
	input wire logic resultReady,
	output logic [SAR_BITS-1:0] resultData
);
	sar_core_t st_r;
	sar_core_t st_nxt;
	logic sclkRise;
	logic sclkFall;
	logic csFall;
	logic csRise;
	logic csLow;
	logic fifoInReady;
	logic fifoOutValid;
	logic [SAR_BITS-1:0] fifoOutData;
	logic [3:0] bitIdx;
	logic [3:0] revIdx;
	logic [4:0] fallNext;
	logic fifoOutReady;

	// edges only from the second sync stage
	assign csLow = !st_r.sync.csSync[1];
	assign sclkRise = st_r.sync.sclkSync[1] && !st_r.sync.sclkPrev;
	assign sclkFall = !st_r.sync.sclkSync[1] && st_r.sync.sclkPrev;
	assign csFall = !st_r.sync.csSync[1] && st_r.sync.csPrev;
	assign csRise = st_r.sync.csSync[1] && !st_r.sync.csPrev;
	assign fallNext = st_r.falls + 5'h01;
	// msb at fall 3 -> bit 11; lsb at fall 14 -> bit 0
	assign bitIdx = 4'(SAR_FALL_LSB - fallNext);
	// repeat: fall 15 -> bit 1 ... fall 25 -> bit 11
	assign revIdx = 4'(fallNext - SAR_FALL_LSB);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.sync.sclkSync = {st_r.sync.sclkSync[0], serClk};
		st_nxt.sync.csSync = {st_r.sync.csSync[0], convSelB};
		st_nxt.sync.sclkPrev = st_r.sync.sclkSync[1];
		st_nxt.sync.csPrev = st_r.sync.csSync[1];
		if (fifoInReady)
		begin
			st_nxt.resultValid = 1'b0;
		end
		// output slice reloads when empty or when its word is taken
		if (fifoOutReady)
		begin
			st_nxt.outValid = fifoOutValid;
			st_nxt.outData = fifoOutData;
		end
		if (csRise)
		begin
			// early select release floats output, no repeat
			st_nxt.state = SAR_IDLE;
			st_nxt.doutOeN = 1'b1;
			st_nxt.doutBit = 1'b0;
		end
		else
		begin
			case (st_r.state)
				SAR_IDLE:
				begin
					if (csFall)
					begin
						st_nxt.state = SAR_RUN;
						st_nxt.falls = SAR_FALL_RESET;
						st_nxt.sample = analogCode;
						st_nxt.result = SAR_CODE_RESET;
						st_nxt.acqOpen = 1'b1;
						// a word still refused by a full queue would be rebuilt half way
						st_nxt.resultValid = 1'b0;
					end
				end
				SAR_RUN:
				begin
					// array tracks the input until the rise after fall 1
					if (st_r.acqOpen)
					begin
						st_nxt.sample = analogCode;
						if (sclkRise && st_r.falls == SAR_FALL_ACQ)
						begin
							st_nxt.acqOpen = 1'b0;
						end
					end
					// bits then follow on counted falls
					if (sclkFall && csLow)
					begin
						st_nxt.falls = fallNext;
						if (fallNext == SAR_FALL_ACQ)
						begin
							// still acquiring, output stays floated
							st_nxt.doutOeN = 1'b1;
						end
						else if (fallNext == SAR_FALL_EN)
						begin
							st_nxt.doutOeN = 1'b0;
							st_nxt.doutBit = 1'b0;
						end
						else if (fallNext >= SAR_FALL_MSB && fallNext <= SAR_FALL_LSB)
						begin
							// resolve one bit per fall, drive it at once
							st_nxt.result[bitIdx] = st_r.sample[bitIdx];
							st_nxt.doutBit = st_r.sample[bitIdx];
							if (fallNext == SAR_FALL_LSB)
							begin
								st_nxt.resultValid = 1'b1;
							end
						end
						else if (fallNext > SAR_FALL_LSB && fallNext <= SAR_FALL_LAST)
						begin
							st_nxt.doutBit = st_r.result[revIdx];
						end
						else
						begin
							st_nxt.state = SAR_DONE;
							st_nxt.doutOeN = 1'b1;
							st_nxt.doutBit = 1'b0;
						end
					end
				end
				SAR_DONE:
				begin
					st_nxt.doutOeN = 1'b1;
				end
				default:
				begin
					st_nxt.state = SAR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_r.sync.sclkSync <= 2'h0;
			st_r.sync.csSync <= 2'h3;
			st_r.sync.sclkPrev <= 1'b0;
			st_r.sync.csPrev <= 1'b1;
			st_r.state <= SAR_IDLE;
			st_r.falls <= SAR_FALL_RESET;
			st_r.sample <= SAR_CODE_RESET;
			st_r.result <= SAR_CODE_RESET;
			st_r.doutBit <= 1'b0;
			st_r.doutOeN <= 1'b1;
			st_r.resultValid <= 1'b0;
			st_r.acqOpen <= 1'b0;
			st_r.outValid <= 1'b0;
			st_r.outData <= SAR_CODE_RESET;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign serDataOut = st_r.doutBit;
	assign serDataOeB = st_r.doutOeN;
	assign resultValid = st_r.outValid;
	assign resultData = st_r.outData;
	// queue head moves only when the slice takes it
	assign fifoOutReady = !st_r.outValid || resultReady;

	sar_fifo #(
		.WIDTH(SAR_BITS),
		.DEPTH(SAR_FIFO_DEPTH)
	) resultFifo (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.inValid(st_r.resultValid),
		.inReady(fifoInReady),
		.inData(st_r.result),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData(fifoOutData)
	);

endmodule
`default_nettype wire

// ==== rtl/sar_pkg.sv ====
// package: constants and carrier types for the sar serial read-out block
// Behaviour
// - no internal conversion clock; host serial clock times conversion and shifting.
// - full conversion and read-out take 26 serial clock cycles from select fall.
// - short cycling needs only 14 or 15 cycles, set by first edge kind.
// - input sample tracked from conversion start, held from the rise after fall 1.
// - acquisition spans first 1.5 serial clocks; host keeps clock running.
// - result shifted out most significant bit first.
// - output bits come from the conversion in progress, resolved bit by bit.
// - continued clocking repeats the result least significant bit first.
// - each bit launched on a serial clock fall, starting with a null bit.
// - one code step is twice reference over 4096, spanning minus to plus.
// - output enabled at second fall with null bit; msb on third fall.
// - select rising by 15th fall ends after lsb; else lsb sent once then repeat.
// - result coded two's complement: 7FF top, 000 mid, 800 bottom.
package sar_pkg;
	localparam int SAR_BITS = 12;
	localparam int SAR_CODES = 4096;
	localparam logic [4:0] SAR_FALL_ACQ = 5'h01;
	localparam logic [4:0] SAR_FALL_EN = 5'h02;
	localparam logic [4:0] SAR_FALL_MSB = 5'h03;
	localparam logic [4:0] SAR_FALL_LSB = 5'h0E;
	localparam logic [4:0] SAR_FALL_SHORT = 5'h0F;
	localparam logic [4:0] SAR_FALL_LAST = 5'h19;
	localparam logic [4:0] SAR_FALL_RESET = 5'h00;
	localparam logic [11:0] SAR_CODE_POS_FS = 12'h07FF;
	localparam logic [11:0] SAR_CODE_NEG_FS = 12'h0800;
	localparam logic [11:0] SAR_CODE_RESET = 12'h0000;
	localparam int SAR_FIFO_DEPTH = 16;

	typedef enum logic [1:0] {SAR_IDLE, SAR_RUN, SAR_DONE} sar_state_t;

	typedef struct packed {
		logic [1:0] sclkSync;
		logic [1:0] csSync;
		logic sclkPrev;
		logic csPrev;
	} sar_sync_t;

	typedef struct packed {
		sar_sync_t sync;
		sar_state_t state;
		logic [4:0] falls;
		logic [11:0] sample;
		logic [11:0] result;
		logic doutBit;
		logic doutOeN;
		logic resultValid;
		logic acqOpen;
		logic outValid;
		logic [11:0] outData;
	} sar_core_t;

	typedef struct packed {
		logic [SAR_BITS-1:0] wr;
		logic [SAR_BITS-1:0] rd;
	} sar_unused_t;
endpackage

// ==== rtl/sar_fifo.sv ====
// generic valid/ready fifo with parameterised width and depth
`timescale 1ns/1ps
`default_nettype none
module sar_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wrPtr;
		logic [AW:0] rdPtr;
	} sar_fifo_st_t;

	logic [WIDTH-1:0] mem [DEPTH];
	sar_fifo_st_t st_r;
	sar_fifo_st_t st_nxt;
	logic full;
	logic empty;
	logic push;
	logic pop;

	assign empty = st_r.wrPtr == st_r.rdPtr;
	assign full = (st_r.wrPtr[AW] != st_r.rdPtr[AW]) && (st_r.wrPtr[AW-1:0] == st_r.rdPtr[AW-1:0]);
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[st_r.rdPtr[AW-1:0]];
	assign push = inValid && !full;
	assign pop = outReady && !empty;

	always_comb
	begin
		st_nxt = st_r;
		if (push)
		begin
			st_nxt.wrPtr = st_r.wrPtr + 1'b1;
		end
		if (pop)
		begin
			st_nxt.rdPtr = st_r.rdPtr + 1'b1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (push)
		begin
			mem[st_r.wrPtr[AW-1:0]] <= inData;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end
endmodule
`default_nettype wire

// ==== dv/sar_readout_monitor.sv ====
// port checker for the sar read-out block
`timescale 1ns/1ps
`default_nettype none
module sar_readout_monitor
	import sar_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// serial link
	input wire logic serClk,
	input wire logic convSelB,
	input wire logic serDataOut,
	input wire logic serDataOeB,
	// result stream
	input wire logic resultValid,
	input wire logic resultReady,
	input wire logic [SAR_BITS-1:0] resultData
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	property p_null; $fell(serDataOeB) |-> !convSelB && !serDataOut; endproperty
	a_null: assert property (p_null) else $error("no null bit");
	property p_enClk; $fell(serDataOeB) |-> !serClk; endproperty
	a_enClk: assert property (p_enClk) else $error("enable off a fall");
	property p_fall;
		!serDataOeB && !$past(serDataOeB) && $changed(serDataOut) |-> !serClk;
	endproperty
	a_fall: assert property (p_fall) else $error("bit moved off a fall");
	property p_hold; serClk [*5] |-> $stable(serDataOut); endproperty
	a_hold: assert property (p_hold) else $error("bit moved while high");
	property p_abort; $rose(convSelB) |-> ##[1:6] serDataOeB; endproperty
	a_abort: assert property (p_abort) else $error("no float on abort");
	property p_idle; convSelB && serDataOeB |=> serDataOeB; endproperty
	a_idle: assert property (p_idle) else $error("enabled while idle");
	property p_float; $rose(serDataOeB) && !convSelB |=> serDataOeB [*8]; endproperty
	a_float: assert property (p_float) else $error("left float early");
	property p_stream; resultValid && !resultReady |=> resultValid && $stable(resultData); endproperty
	a_stream: assert property (p_stream) else $error("word dropped");
endmodule
`default_nettype wire

// ==== dv/sar_host_model.sv ====
// host serial master model for the sar read-out link
`timescale 1ns/1ps
`default_nettype none
module sar_host_model (
	// serial link
	output logic serClk,
	output logic convSelB,
	input wire logic serDataOut,
	input wire logic serDataOeB,
	// wire level seen at each clock rise, z while floated
	output logic [31:0] rxBits
);
	initial
	begin
		serClk = 1'b0;
		convSelB = 1'b1;
	end
	task automatic frame(input int n, input logic sel);
		rxBits = '0;
		// step off the sampling edge before touching the pins
		#2;
		convSelB = sel;
		repeat (n)
		begin
			#62.5 serClk = 1'b1;
			rxBits = {rxBits[30:0], serDataOeB ? 1'bz : serDataOut};
			#62.5 serClk = 1'b0;
		end
		convSelB = 1'b1;
		#600;
	endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the sar read-out block
`timescale 1ns/1ps
`default_nettype none
module tb
	import sar_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic resultReady = 1'b0;
	logic [SAR_BITS-1:0] analogCode = '0;
	logic serClk, convSelB, serDataOut, serDataOeB, resultValid;
	logic [SAR_BITS-1:0] resultData;
	logic [31:0] rxBits;
	logic [SAR_BITS-1:0] expQ[$];
	logic [SAR_BITS-1:0] fsCodes[3] = '{SAR_CODE_POS_FS, SAR_CODE_NEG_FS, SAR_CODE_RESET};
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	int seed = 32'h7dff;
	always #5 core_clk = ~core_clk;
	sar_readout u_dut (.core_clk, .rst_b, .serClk, .convSelB, .serDataOut, .serDataOeB,
		.analogCode, .resultValid, .resultReady, .resultData);
	sar_host_model u_host (.serClk, .convSelB, .serDataOut, .serDataOeB, .rxBits);
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_word(input logic [SAR_BITS-1:0] got, input logic [SAR_BITS-1:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t word got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic run(input int n, input logic sel, input logic [SAR_BITS-1:0] code);
		logic [31:0] exp;
		exp = '0;
		@(posedge core_clk);
		analogCode <= code;
		if (!sel && n > 13)
			expQ.push_back(code);
		for (int f = 0; f < n; f++)
			exp = {exp[30:0], sel || f < 2 || f > 25 ? 1'bz :
				f < 15 ? f > 2 && code[14-f] : code[f-14]};
		u_host.frame(n, sel);
		cmp(rxBits, exp);
	endtask
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		resultReady <= 1'($random(seed));
		if (resultValid === 1'b1 && resultReady === 1'b1)
			cmp_word(resultData, expQ.size() > 0 ? expQ.pop_front() : 12'hxxx);
		if (cyc == 20000)
		begin
			error_cnt++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge core_clk);
		foreach (fsCodes[i])
			run(26, 1'b0, fsCodes[i]);
		repeat (5)
			run(26, 1'b0, 12'($random(seed)));
		run(15, 1'b0, 12'h0C3A);
		run(30, 1'b0, 12'($random(seed)));
		run(20, 1'b1, 12'h0FFF);
		repeat (100) @(posedge core_clk);
		cmp(32'(expQ.size()), 32'h0000_0000);
		give_verdict();
	end
endmodule
bind sar_readout sar_readout_monitor u_mon (.core_clk, .rst_b, .serClk, .convSelB,
	.serDataOut, .serDataOeB, .resultValid, .resultReady, .resultData);
`default_nettype wire
